//--- shared/vopc_map.svh
`ifndef VOPC_MAP_SVH
`define VOPC_MAP_SVH
// Function
// - Output timing locks to frame reference 1, frame reference 2 or local.
// - A new output format applies only once the chosen reference matches it.
// - Each output carries program, preview or a chosen clean feed.
// - Reset routing: outputs 1-2 program, output 3 preview, output 4 clean.
// - Dithering off by default, else 2, 3 or 4 bits for low/med/high.
// - Black clipping limits samples to black level; off passes below black.
// - White clipping limits samples to white level; off passes above white.
// - Line-21 pass-through forwards line 21 unchanged, bypassing the mix.
// - With pass-through cleared, line 21 is processed as active picture.
// - Enabled alarm rises when its input is absent or invalid; on by default.
// - A cleared alarm enable keeps that input's alarm low.
// - Audio mixing enabled crossfades embedded audio with the transition.
// - Audio mixing disabled hard-cuts audio between sources, no blending.
// - Inputs outside about half a line are flagged for vertical shift.

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define VOPC_ADDR_REF 4'h0
`define VOPC_ADDR_FMT 4'h1
`define VOPC_ADDR_ROUTE 4'h2
`define VOPC_ADDR_PROC 4'h3
`define VOPC_ADDR_ALARM 4'h4
`define VOPC_ADDR_AUDIO 4'h5
`define VOPC_ADDR_STATUS 4'h6

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define VOPC_RST_REF 2'h0
`define VOPC_RST_FMT 3'h0
`define VOPC_RST_ROUTE 8'h90
`define VOPC_RST_PROC 5'h00
`define VOPC_RST_ALARM 4'hf
`define VOPC_RST_AUDIO 1'h1
`define VOPC_REF_INVALID 2'h3
`define VOPC_PROC_CLIPB 2
`define VOPC_PROC_CLIPW 3
`define VOPC_PROC_L21 4

// ----------------------------------------------------------------------
// Video levels and timing
// ----------------------------------------------------------------------
`define VOPC_BLACK 10'h040
`define VOPC_WHITE 10'h3ac
`define VOPC_CAPTION_LINE 11'h015
`define VOPC_LFSR_SEED 16'hace1
`endif

//--- shared/vopc_pkg.sv
package vopc_pkg;
    typedef logic [9:0] vopc_sample_t;
    typedef logic [2:0] vopc_fmt_t;
    typedef logic [1:0] vopc_route_t;
    typedef enum logic [1:0] {
        VOPC_DITH_OFF = 2'h0,
        VOPC_DITH_LOW = 2'h1,
        VOPC_DITH_MED = 2'h2,
        VOPC_DITH_HIGH = 2'h3
    } vopc_dither_e;
    typedef enum logic [1:0] {
        VOPC_FMT_STABLE = 2'b01,
        VOPC_FMT_WAIT = 2'b10
    } vopc_fmt_state_e;
endpackage : vopc_pkg

//--- shared/vopc_px_if.sv
interface vopc_px_if;
    import vopc_pkg::*;
    vopc_sample_t [3:0] din;
    vopc_sample_t [3:0] dout;
    logic valid_in;
    logic valid_out;
    vopc_dither_e dither;
    logic clip_black;
    logic clip_white;
    modport top (output din, valid_in, dither, clip_black, clip_white,
                 input dout, valid_out);
    modport proc (input din, valid_in, dither, clip_black, clip_white,
                  output dout, valid_out);
endinterface : vopc_px_if

//--- rtl/vopc_pixel.sv
`include "vopc_map.svh"
module vopc_pixel
    import vopc_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    vopc_px_if.proc px
);
    logic [15:0] lfsr_r;

    // ------------------------------------------------------------------
    // Sample shaping
    // ------------------------------------------------------------------
    // Noise is added and the low bits then dropped, so the output depth
    // shrinks by the dither width; saturation avoids wrap at full white.
    function automatic vopc_sample_t vopc_shape(input vopc_sample_t s,
            input logic [3:0] noise, input vopc_dither_e d,
            input logic cb, input logic cw);
        logic [10:0] sum;
        logic [9:0] mask;
        logic [9:0] v;
        case (d)
            VOPC_DITH_LOW: mask = 10'h003;
            VOPC_DITH_MED: mask = 10'h007;
            VOPC_DITH_HIGH: mask = 10'h00f;
            default: mask = 10'h000;
        endcase
        sum = {1'b0, s} + {7'h00, noise & mask[3:0]};
        v = sum[10] ? 10'h3ff : sum[9:0];
        v = v & ~mask;
        if (cb && v < `VOPC_BLACK) begin
            v = `VOPC_BLACK;
        end
        if (cw && v > `VOPC_WHITE) begin
            v = `VOPC_WHITE;
        end
        return v;
    endfunction : vopc_shape

    always_ff @(posedge clock) begin
        if (reset) begin
            lfsr_r <= `VOPC_LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[14:0],
                       lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            px.dout <= '0;
            px.valid_out <= 1'b0;
        end else begin
            px.valid_out <= px.valid_in;
            for (int i = 0; i < 4; i++) begin
                px.dout[i] <= vopc_shape(px.din[i], lfsr_r[4*i +: 4],
                                         px.dither, px.clip_black,
                                         px.clip_white);
            end
        end
    end

    default clocking cb_px @(posedge clock); endclocking
    default disable iff (reset);

    chk_black_floor: assert property (px.valid_in && px.clip_black |=>
        px.dout[0] >= `VOPC_BLACK && px.dout[3] >= `VOPC_BLACK)
        else $error("black clip let a sample below black");
    chk_white_ceiling: assert property (px.valid_in && px.clip_white |=>
        px.dout[0] <= `VOPC_WHITE && px.dout[3] <= `VOPC_WHITE)
        else $error("white clip let a sample above white");
    chk_dither_off: assert property (px.valid_in
        && px.dither == VOPC_DITH_OFF && !px.clip_black && !px.clip_white
        |=> px.dout == $past(px.din))
        else $error("sample altered with dither and clipping off");
    chk_dither_depth: assert property (px.valid_in
        && px.dither == VOPC_DITH_HIGH && !px.clip_black && !px.clip_white
        |=> px.dout[1][3:0] == 4'h0)
        else $error("high dither left low bits set");
endmodule : vopc_pixel

//--- rtl/vopc_top.sv
`include "vopc_map.svh"
module vopc_top
    import vopc_pkg::*;
#(
    parameter int AUDIO_W = 24
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic [2:0] ref_present,
    input wire logic [2:0] ref_fmt_frame1,
    input wire logic [2:0] ref_fmt_frame2,
    input wire logic [2:0] ref_fmt_local,
    output logic [1:0] timing_ref_sel,
    output logic [2:0] out_format,
    output logic ref_locked,
    input wire logic frame_start,
    input wire logic [10:0] line_num,
    input wire logic sample_valid,
    input wire logic [9:0] program_s,
    input wire logic [9:0] preview_s,
    input wire logic [9:0] clean1_s,
    input wire logic [9:0] clean2_s,
    input wire logic [9:0] bypass_s,
    output vopc_sample_t [3:0] vid_out,
    output logic vid_valid,
    input wire logic [3:0] in_present,
    input wire logic [3:0] in_valid,
    input wire logic [3:0] in_offset_ok,
    output logic [3:0] alarm,
    output logic [3:0] vshift,
    input wire logic signed [AUDIO_W-1:0] audio_a,
    input wire logic signed [AUDIO_W-1:0] audio_b,
    input wire logic audio_valid,
    input wire logic [7:0] mix_pos,
    output logic signed [AUDIO_W-1:0] audio_out,
    output logic audio_out_valid
);
    vopc_px_if px ();

    vopc_fmt_state_e fmt_state_r;
    vopc_fmt_t fmt_req_r;
    logic [7:0] route_shadow_r;
    logic [7:0] route_act_r;
    logic [4:0] proc_shadow_r;
    logic [4:0] proc_act_r;
    logic [3:0] alarm_en_r;
    logic mix_en_r;
    logic fmt_compat;
    logic sel_present;
    logic l21_bypass;
    logic [AUDIO_W+10:0] acc;
    logic [8:0] w_a;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] vopc_pick3(input logic [1:0] sel,
            input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
        case (sel)
            2'h1: return b;
            2'h2: return c;
            default: return a;
        endcase
    endfunction : vopc_pick3

    function automatic vopc_sample_t vopc_route(input vopc_route_t code,
            input vopc_sample_t prog, input vopc_sample_t prev,
            input vopc_sample_t c1, input vopc_sample_t c2);
        case (code)
            2'h1: return prev;
            2'h2: return c1;
            2'h3: return c2;
            default: return prog;
        endcase
    endfunction : vopc_route

    function automatic logic vopc_hit(input logic [3:0] addr);
        return reg_write && reg_addr == addr;
    endfunction : vopc_hit

    assign sel_present = ref_present[timing_ref_sel];
    assign fmt_compat = sel_present && vopc_pick3(timing_ref_sel,
        ref_fmt_frame1, ref_fmt_frame2, ref_fmt_local) == fmt_req_r;
    assign l21_bypass = proc_act_r[`VOPC_PROC_L21]
        && line_num == `VOPC_CAPTION_LINE;

    // ------------------------------------------------------------------
    // Reference and format
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            timing_ref_sel <= `VOPC_RST_REF;
        end else if (vopc_hit(`VOPC_ADDR_REF)
                     && reg_wdata[1:0] != `VOPC_REF_INVALID) begin
            timing_ref_sel <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ref_locked <= 1'b0;
        end else begin
            ref_locked <= sel_present;
        end
    end

    // A request written while another waits simply replaces it; the
    // active format only moves on a match, so a missing reference leaves
    // the output running on the last good format.
    always_ff @(posedge clock) begin
        if (reset) begin
            fmt_state_r <= VOPC_FMT_STABLE;
            fmt_req_r <= `VOPC_RST_FMT;
            out_format <= `VOPC_RST_FMT;
        end else if (vopc_hit(`VOPC_ADDR_FMT)) begin
            fmt_req_r <= reg_wdata[2:0];
            fmt_state_r <= VOPC_FMT_WAIT;
        end else begin
            case (fmt_state_r)
                VOPC_FMT_WAIT: begin
                    if (fmt_compat) begin
                        out_format <= fmt_req_r;
                        fmt_state_r <= VOPC_FMT_STABLE;
                    end
                end
                VOPC_FMT_STABLE: begin
                    fmt_state_r <= VOPC_FMT_STABLE;
                end
                default: begin
                    fmt_state_r <= VOPC_FMT_STABLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Processing settings, taken up at the frame boundary
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            route_shadow_r <= `VOPC_RST_ROUTE;
            proc_shadow_r <= `VOPC_RST_PROC;
        end else begin
            if (vopc_hit(`VOPC_ADDR_ROUTE)) begin
                route_shadow_r <= reg_wdata[7:0];
            end
            if (vopc_hit(`VOPC_ADDR_PROC)) begin
                proc_shadow_r <= reg_wdata[4:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            route_act_r <= `VOPC_RST_ROUTE;
            proc_act_r <= `VOPC_RST_PROC;
        end else if (frame_start) begin
            route_act_r <= route_shadow_r;
            proc_act_r <= proc_shadow_r;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            px.din <= '0;
            px.valid_in <= 1'b0;
        end else begin
            px.valid_in <= sample_valid;
            for (int i = 0; i < 4; i++) begin
                px.din[i] <= l21_bypass ? bypass_s
                    : vopc_route(route_act_r[2*i +: 2], program_s,
                                 preview_s, clean1_s, clean2_s);
            end
        end
    end

    // Bypassed caption samples must also skip dither and clipping.
    always_ff @(posedge clock) begin
        if (reset) begin
            px.dither <= VOPC_DITH_OFF;
            px.clip_black <= 1'b0;
            px.clip_white <= 1'b0;
        end else begin
            px.dither <= l21_bypass ? VOPC_DITH_OFF
                : vopc_dither_e'(proc_act_r[1:0]);
            px.clip_black <= !l21_bypass
                && proc_act_r[`VOPC_PROC_CLIPB];
            px.clip_white <= !l21_bypass
                && proc_act_r[`VOPC_PROC_CLIPW];
        end
    end

    vopc_pixel u_pixel (
        .clock(clock),
        .reset(reset),
        .px(px.proc)
    );

    assign vid_out = px.dout;
    assign vid_valid = px.valid_out;

    // ------------------------------------------------------------------
    // Alarms and timing status
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            alarm_en_r <= `VOPC_RST_ALARM;
        end else if (vopc_hit(`VOPC_ADDR_ALARM)) begin
            alarm_en_r <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            alarm <= 4'h0;
            vshift <= 4'h0;
        end else begin
            alarm <= alarm_en_r & ~(in_present & in_valid);
            vshift <= in_present & ~in_offset_ok;
        end
    end

    // ------------------------------------------------------------------
    // Embedded audio
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            mix_en_r <= `VOPC_RST_AUDIO;
        end else if (vopc_hit(`VOPC_ADDR_AUDIO)) begin
            mix_en_r <= reg_wdata[0];
        end
    end

    assign w_a = 9'h100 - {1'b0, mix_pos};
    assign acc = (AUDIO_W+11)'(audio_a) * (AUDIO_W+11)'($signed({1'b0, w_a}))
        + (AUDIO_W+11)'(audio_b)
        * (AUDIO_W+11)'($signed({2'b00, mix_pos}));

    // The cut point sits at the middle of the transition so compressed
    // streams are never blended; the price is a mid-transition jump.
    always_ff @(posedge clock) begin
        if (reset) begin
            audio_out <= '0;
            audio_out_valid <= 1'b0;
        end else begin
            audio_out_valid <= audio_valid;
            if (audio_valid) begin
                if (mix_en_r) begin
                    audio_out <= acc[AUDIO_W+7:8];
                end else begin
                    audio_out <= mix_pos[7] ? audio_b : audio_a;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                `VOPC_ADDR_REF: reg_rdata <= {14'h0000, timing_ref_sel};
                `VOPC_ADDR_FMT: reg_rdata <= {8'h00,
                    fmt_state_r == VOPC_FMT_WAIT, out_format, 1'b0,
                    fmt_req_r};
                `VOPC_ADDR_ROUTE: reg_rdata <= {8'h00, route_shadow_r};
                `VOPC_ADDR_PROC: reg_rdata <= {11'h000, proc_shadow_r};
                `VOPC_ADDR_ALARM: reg_rdata <= {12'h000, alarm_en_r};
                `VOPC_ADDR_AUDIO: reg_rdata <= {15'h0000, mix_en_r};
                `VOPC_ADDR_STATUS: reg_rdata <= {7'h00, ref_locked,
                    vshift, alarm};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb_top @(posedge clock); endclocking
    default disable iff (reset);

    // The strobe is tested directly here: a function that reads module
    // nets would see their current values, not the sampled ones.
    sequence seq_fmt_waiting;
        fmt_state_r == VOPC_FMT_WAIT
            && !(reg_write && reg_addr == `VOPC_ADDR_FMT);
    endsequence
    sequence seq_caption;
        sample_valid && l21_bypass;
    endsequence

    chk_ref_select: assert property (reg_write
        && reg_addr == `VOPC_ADDR_REF
        && reg_wdata[1:0] != `VOPC_REF_INVALID
        |=> timing_ref_sel == $past(reg_wdata[1:0]))
        else $error("reference select not taken");
    chk_fmt_hold: assert property (seq_fmt_waiting and !fmt_compat
        |=> $stable(out_format))
        else $error("format changed before reference matched");
    chk_fmt_apply: assert property (seq_fmt_waiting and fmt_compat
        |=> out_format == $past(fmt_req_r) ##1 $stable(out_format))
        else $error("format not applied on matching reference");
    chk_reset_route: assert property (disable iff (1'b0)
        reset |=> route_act_r == `VOPC_RST_ROUTE)
        else $error("reset routing wrong");
    chk_route_frame: assert property (!frame_start
        |=> $stable(route_act_r) && $stable(proc_act_r))
        else $error("settings changed away from frame boundary");
    chk_caption_pass: assert property (seq_caption
        |=> px.din[2] == $past(bypass_s) ##1 vid_out[2] == $past(bypass_s, 2))
        else $error("caption line altered");
    chk_line_normal: assert property (sample_valid
        && !l21_bypass && route_act_r[1:0] == 2'h0
        |=> px.din[0] == $past(program_s))
        else $error("routed sample wrong");
    chk_alarm_raise: assert property (alarm_en_r[0] && !in_present[0]
        |=> alarm[0])
        else $error("alarm not raised");
    chk_alarm_mask: assert property (!alarm_en_r[1] ##1 !alarm_en_r[1]
        |-> !alarm[1])
        else $error("masked alarm raised");
    chk_audio_cut: assert property (!mix_en_r && audio_valid
        && mix_pos[7] |=> audio_out == $past(audio_b))
        else $error("hard cut audio wrong");
    chk_audio_mix: assert property (mix_en_r && audio_valid
        && mix_pos == 8'h00 |=> audio_out == $past(audio_a))
        else $error("crossfade start not source A");
    chk_vshift: assert property (in_present[2] && !in_offset_ok[2]
        |=> vshift[2])
        else $error("vertical shift flag missing");
endmodule : vopc_top

//--- verification/vopc_src_model.sv
// ----------------------------------------------------------------------
// Upstream timing source: 32 lines of 4 samples, one frame pulse each
// ----------------------------------------------------------------------
module vopc_src_model (
    input wire logic clock,
    input wire logic reset,
    output logic frame_start,
    output logic [10:0] line_num,
    output logic sample_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] pos_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            pos_r <= 7'h00;
        end else begin
            pos_r <= pos_r + 7'h01;
        end
    end
    // Short lines keep a whole frame at 128 cycles, so each frame wait is
    // cheap; the line count still passes the caption line every frame.
    always_ff @(posedge clock) begin
        frame_start <= !reset && pos_r == 7'h7f;
        line_num <= {6'h00, pos_r[6:2]};
        sample_valid <= !reset;
    end
endmodule : vopc_src_model

//--- verification/tb_vopc_top.sv
`include "vopc_map.svh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin \
    fails++; $display("mismatch at %0t: %s", $time, m); end end
module tb_vopc_top
    import vopc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [2:0] ref_present = 3'h7, fmt1 = 3'h0, fmt2 = 3'h0, fmtl = 3'h0;
    logic [2:0] out_format;
    logic [1:0] timing_ref_sel;
    logic ref_locked, frame_start, sample_valid, vid_valid, aout_v;
    logic [10:0] line_num;
    logic [9:0] prog = 10'h100, prev = 10'h200, cl1 = 10'h300;
    logic [9:0] cl2 = 10'h150, byp = 10'h0aa;
    vopc_sample_t [3:0] vid_out;
    logic [3:0] in_present = 4'hf, in_valid = 4'hf, in_ok = 4'hf;
    logic [3:0] alarm, vshift;
    logic signed [23:0] aud_a = 24'sh00_03e8, aud_b = 24'sh00_07d0;
    logic signed [23:0] audio_out;
    logic aud_v = 1'b1;
    logic [7:0] mix_pos = 8'h80;
    int fails = 0, compares = 0;

    initial begin
        forever #50 clock = ~clock;
    end

    vopc_src_model vopc_src_model_i (.clock(clock), .reset(reset),
        .frame_start(frame_start), .line_num(line_num),
        .sample_valid(sample_valid));

    vopc_top #(.AUDIO_W(24)) vopc_top_i (.clock(clock), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .ref_present(ref_present), .ref_fmt_frame1(fmt1),
        .ref_fmt_frame2(fmt2), .ref_fmt_local(fmtl),
        .timing_ref_sel(timing_ref_sel), .out_format(out_format),
        .ref_locked(ref_locked), .frame_start(frame_start),
        .line_num(line_num), .sample_valid(sample_valid),
        .program_s(prog), .preview_s(prev), .clean1_s(cl1),
        .clean2_s(cl2), .bypass_s(byp), .vid_out(vid_out),
        .vid_valid(vid_valid), .in_present(in_present),
        .in_valid(in_valid), .in_offset_ok(in_ok), .alarm(alarm),
        .vshift(vshift), .audio_a(aud_a), .audio_b(aud_b),
        .audio_valid(aud_v), .mix_pos(mix_pos), .audio_out(audio_out),
        .audio_out_valid(aout_v));

    // ------------------------------------------------------------------
    // Bus and timing helpers
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // Outputs are looked at 1 ns after the edge, once its updates landed.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Returns at the edge where the frame pulse or line 21 is sampled.
    task automatic wait_ev(input bit line);
        bit hit;
        hit = 1'b0;
        for (int i = 0; i < 300 && !hit; i++) begin
            @(posedge clock);
            hit = line ? line_num === 11'h015 : frame_start === 1'b1;
        end
        if (!hit) begin
            fails++;
            $display("mismatch at %0t: wait timed out", $time);
            close_out();
        end
    endtask : wait_ev

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] d;
        logic [15:0] exp [8];
        logic [15:0] pv [4];
        logic [9:0] pin [4];
        logic [9:0] pex [4];
        logic [9:0] mask;
        exp = '{16'h0000, 16'h0000, 16'h0090, 16'h0000, 16'h000f, 16'h0001,
                16'h0100, 16'h0000};
        pv = '{16'h0004, 16'h0000, 16'h0008, 16'h0000};
        pin = '{10'h010, 10'h010, 10'h3f0, 10'h3f0};
        pex = '{10'h040, 10'h010, 10'h3ac, 10'h3f0};
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), d);
            `CHK(d, exp[i], "reset value")
        end
        $display("test reset values done");
        wr(`VOPC_ADDR_REF, 16'h0002);
        wr(`VOPC_ADDR_REF, 16'h0003);
        rd(`VOPC_ADDR_REF, d);
        `CHK(d, 16'h0002, "reference select")
        `CHK(timing_ref_sel, 2'h2, "timing reference")
        wr(`VOPC_ADDR_FMT, 16'h0003);
        step(3);
        `CHK(out_format, 3'h0, "format held")
        @(posedge clock);
        fmtl <= 3'h3;
        step(3);
        `CHK(out_format, 3'h3, "format applied")
        @(posedge clock);
        ref_present <= 3'h5;
        fmt2 <= 3'h5;
        wr(`VOPC_ADDR_REF, 16'h0001);
        wr(`VOPC_ADDR_FMT, 16'h0005);
        step(3);
        `CHK(out_format, 3'h3, "format held, reference lost")
        `CHK(ref_locked, 1'b0, "reference lost")
        @(posedge clock);
        ref_present <= 3'h7;
        step(3);
        `CHK(out_format, 3'h5, "format on second reference")
        `CHK(ref_locked, 1'b1, "reference locked")
        $display("test reference and format done");
        wait_ev(0);
        step(3);
        `CHK(vid_out, {cl1, prev, prog, prog}, "reset routing")
        `CHK(vid_valid, 1'b1, "video valid")
        wait_ev(0);
        wr(`VOPC_ADDR_ROUTE, 16'h001b);
        step(3);
        `CHK(vid_out, {cl1, prev, prog, prog}, "routing held")
        wait_ev(0);
        step(3);
        `CHK(vid_out, {prog, prev, cl1, cl2}, "new routing")
        $display("test routing done");
        for (int i = 0; i < 4; i++) begin
            wr(`VOPC_ADDR_PROC, pv[i]);
            @(posedge clock);
            prog <= pin[i];
            wait_ev(0);
            step(3);
            `CHK(vid_out[3], pex[i], "clipping")
        end
        @(posedge clock);
        prog <= 10'h155;
        for (int n = 1; n < 4; n++) begin
            wr(`VOPC_ADDR_PROC, 16'(n));
            wait_ev(0);
            step(3);
            mask = 10'((1 << (n + 1)) - 1);
            `CHK(vid_out[3] & mask, 10'h000, "dither depth")
        end
        $display("test processing done");
        @(posedge clock);
        prog <= 10'h123;
        wr(`VOPC_ADDR_PROC, 16'h0010);
        wait_ev(0);
        wait_ev(1);
        step(2);
        `CHK(vid_out, {4{byp}}, "line 21 bypass")
        wr(`VOPC_ADDR_PROC, 16'h0000);
        wait_ev(0);
        wait_ev(1);
        step(2);
        `CHK(vid_out[3], prog, "line 21 as picture")
        $display("test line 21 done");
        @(posedge clock);
        in_present <= 4'ha;
        in_ok <= 4'h0;
        step(2);
        `CHK(alarm, 4'h5, "alarm raised")
        `CHK(vshift, 4'ha, "shift flag")
        @(posedge clock);
        in_present <= 4'hf;
        in_valid <= 4'h5;
        step(2);
        `CHK(alarm, 4'ha, "alarm on invalid")
        wr(`VOPC_ADDR_ALARM, 16'h000d);
        step(2);
        `CHK(alarm, 4'h8, "alarm suppressed")
        rd(`VOPC_ADDR_STATUS, d);
        `CHK(d, 16'h01f8, "status word")
        $display("test alarms done");
        @(posedge clock);
        mix_pos <= 8'h00;
        step(2);
        `CHK(audio_out, 24'sh00_03e8, "crossfade start")
        `CHK(aout_v, 1'b1, "audio valid")
        @(posedge clock);
        mix_pos <= 8'h80;
        step(2);
        `CHK(audio_out, 24'sh00_05dc, "crossfade")
        wr(`VOPC_ADDR_AUDIO, 16'h0000);
        step(2);
        `CHK(audio_out, 24'sh00_07d0, "hard cut second")
        @(posedge clock);
        mix_pos <= 8'h7f;
        step(2);
        `CHK(audio_out, 24'sh00_03e8, "hard cut first")
        $display("test audio done");
        close_out();
    end
endmodule : tb_vopc_top
